// *** pfcs_pkg.sv ***
package pfcs_pkg;

    // Configuration modes of the sequencer.
    localparam logic MODE_INIT_UPDATE = 1'b0;
    localparam logic MODE_UPDATE_ONLY = 1'b1;

    // Link rate codes.
    localparam logic [1:0] RATE_GEN1 = 2'h0;
    localparam logic [1:0] RATE_GEN2 = 2'h1;
    localparam logic [1:0] RATE_GEN3 = 2'h2;

    // Link width codes.
    localparam logic [1:0] WIDTH_X1 = 2'h0;
    localparam logic [1:0] WIDTH_X4 = 2'h1;
    localparam logic [1:0] WIDTH_X8 = 2'h2;

    // Register offsets.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_LINK = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_COUNT = 4'h3;

    // Control register field positions.
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_INIT_EN_BIT = 1;
    localparam int CTRL_UPDATE_BIT = 2;

    // Link register field positions.
    localparam int LINK_RATE_LSB = 0;
    localparam int LINK_WIDTH_LSB = 2;

    // Reset values.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
    localparam logic [31:0] LINK_RESET = 32'h0000_0001;

    // Initialization phase length.
    localparam int INIT_TIME_NS = 800;
    localparam int CLK_PERIOD_NS = 8;
    localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;

    // Stream word width and FIFO depth.
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 4;

    // Fabric image word with end-of-image marker.
    typedef struct packed {
        logic last;
        logic [DATA_W-1:0] data;
    } pfcs_word_t;

    // Completion status codes for host requests, before and after the fabric is up.
    localparam logic [1:0] CPL_OK = 2'h0;
    localparam logic [1:0] CPL_RETRY = 2'h1;
    localparam logic [1:0] CPL_UNSUP = 2'h2;

    // Sequencer states, one-hot.
    typedef enum logic [6:0] {
        ST_PERIPH = 7'h01,
        ST_FULL = 7'h02,
        ST_TRAIN = 7'h04,
        ST_FABRIC = 7'h08,
        ST_INIT = 7'h10,
        ST_USER = 7'h20,
        ST_UPDATE = 7'h40
    } pfcs_state_t;

endpackage

// *** pfcs_fifo.sv ***
`timescale 1ns/1ps
module pfcs_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic in_valid, // Write side word valid.
    output logic in_ready, // Write side may accept.
    input wire logic [WIDTH-1:0] in_data, // Write side word.
    output logic out_valid, // Read side word present.
    input wire logic out_ready, // Read side takes the word.
    output logic [WIDTH-1:0] out_data // Read side word, registered.
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers; count is one bit wider to tell full from empty.
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic out_full;

    wire do_wr = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // Head register refills when empty or being drained.
    wire load = (count != '0) && (!out_full || pop);

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = out_full;

    // Write into the array.
    always_ff @(posedge clk_sys) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, occupancy and the registered head word.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_full <= 1'b0;
            out_data <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (load) begin
                out_data <= mem[rd_ptr];
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(load);
            out_full <= load || (out_full && !pop);
        end
    end
endmodule

// *** pfcs_sequencer.sv ***
// What this block does
// - Init-update mode: periphery first, then fabric over link.
// - Power up loads periphery over conventional interface.
// - Periphery done high before link training may start.
// - Fabric done high after fabric image loaded.
// - Initialize, then user mode; init done if enabled.
// - Update-only mode: full load, then periphery done.
// - Gen3 allowed only in update-only mode.
// - Gen1 and Gen2 allow x1, x4, x8 widths.
// - Fabric-load and user link settings identical.
// - Only designated block feeds configuration controller.
// - User mode carries traffic and accepts updates.
// - After periphery, before fabric ready: retry config, unsupport memory.
// - Update drops fabric done, raises it when finished.
`timescale 1ns/1ps
module pfcs_sequencer
    import pfcs_pkg::*;
(
    input wire logic clk_sys, // System clock, 125 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [3:0] reg_addr, // Register address.
    input wire logic [31:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    output logic [31:0] reg_rdata, // Read data, cycle after strobe.
    input wire logic conv_done, // Conventional image load finished.
    input wire logic link_up, // Designated link reached active state.
    output logic train_enable, // Allows link training to begin.
    output logic [1:0] link_rate, // Link rate used everywhere.
    output logic [1:0] link_width, // Link width used everywhere.
    input wire logic img_valid, // Fabric word from designated link.
    output logic img_ready, // Sequencer accepts fabric word.
    input wire logic [DATA_W-1:0] img_data, // Fabric image word.
    input wire logic img_last, // Last word of the fabric image.
    input wire logic other_img_valid, // Fabric word from another block.
    output logic other_img_ready, // Always refused.
    output logic [DATA_W-1:0] cfg_data, // Word to configuration array.
    output logic cfg_valid, // Configuration word strobe.
    input wire logic cfg_ready, // Configuration array can take word.
    input wire logic req_valid, // Host request arrives.
    input wire logic req_is_cfg, // Request is a configuration access.
    output logic cpl_valid, // Completion ready.
    output logic [1:0] cpl_status, // Completion status code.
    output logic periphery_done, // Periphery or full load done.
    output logic fabric_done, // Fabric image loaded.
    output logic init_done, // Initialization finished.
    output logic user_mode // Device in user mode.
);
    // State, registers and counters.
    pfcs_state_t state;
    pfcs_state_t next_state;
    logic [31:0] ctrl;
    logic [31:0] link_cfg;
    logic [31:0] word_count;
    logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt;
    logic update_req;
    logic [1:0] latched_rate;
    logic [1:0] latched_width;

    // FIFO interface wires.
    pfcs_word_t fifo_in;
    pfcs_word_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;

    // Decoded register fields.
    wire mode_sel = ctrl[CTRL_MODE_BIT];
    wire init_en = ctrl[CTRL_INIT_EN_BIT];
    wire [1:0] req_rate = link_cfg[LINK_RATE_LSB +: 2];
    wire [1:0] req_width = link_cfg[LINK_WIDTH_LSB +: 2];
    wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wire wr_link = reg_wr && (reg_addr == REG_LINK);

    // Gen3 is refused in init-update mode; unknown codes fall back.
    wire rate_ok = (req_rate == RATE_GEN1) || (req_rate == RATE_GEN2) ||
        ((req_rate == RATE_GEN3) && (mode_sel == MODE_UPDATE_ONLY));
    wire width_ok = (req_width == WIDTH_X1) || (req_width == WIDTH_X4) ||
        (req_width == WIDTH_X8);

    // Loading states that consume the image stream.
    wire loading = (state == ST_FABRIC) || (state == ST_UPDATE);
    wire fabric_up = (state == ST_INIT) || (state == ST_USER);
    wire image_end = fifo_out_valid && fifo_out_ready && fifo_out.last;
    // Leaving a load state straight into init means a full image landed.
    // This covers the shortcut taken when the load ends at the mode choice.
    wire full_loaded = (next_state == ST_INIT) &&
        ((state == ST_PERIPH) || (state == ST_FULL));

    // Only the designated link feeds the FIFO; other blocks never do.
    assign fifo_in.data = img_data;
    assign fifo_in.last = img_last;
    assign img_ready = fifo_in_ready && loading;
    assign other_img_ready = 1'b0;
    assign fifo_out_ready = cfg_ready && loading;

    // Image words buffered before the configuration array.
    pfcs_fifo #(
        .WIDTH($bits(pfcs_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(img_valid && loading),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    // Handshake to the configuration array passes straight through.
    assign cfg_valid = fifo_out_valid && loading;
    assign cfg_data = fifo_out.data;

    // Link training held off until periphery is in place.
    assign train_enable = periphery_done;
    // One link setting serves fabric loading and the user application.
    assign link_rate = latched_rate;
    assign link_width = latched_width;

    // Next state logic.
    always_comb begin
        next_state = state;
        case (state)
            ST_PERIPH: begin
                // The mode is sampled here, so it must be set before the load
                // ends; a later change of mode has no effect on this path.
                if (mode_sel == MODE_UPDATE_ONLY) begin
                    next_state = conv_done ? ST_INIT : ST_FULL;
                end else if (conv_done) begin
                    next_state = ST_TRAIN;
                end
            end
            ST_FULL: begin
                if (conv_done) begin
                    next_state = ST_INIT;
                end
            end
            ST_TRAIN: begin
                // The host waits for an active link before sending.
                if (link_up) begin
                    next_state = ST_FABRIC;
                end
            end
            ST_FABRIC: begin
                if (image_end) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                if (init_cnt == '0) begin
                    next_state = ST_USER;
                end
            end
            ST_USER: begin
                if (update_req) begin
                    next_state = ST_UPDATE;
                end
            end
            ST_UPDATE: begin
                if (image_end) begin
                    next_state = ST_INIT;
                end
            end
            default: begin
                next_state = ST_PERIPH;
            end
        endcase
    end

    // State register; the mode picks its path in the next state logic, so
    // the done flags and the init timer always see the same transition.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ST_PERIPH;
        end else begin
            state <= next_state;
        end
    end

    // Control and link registers; the update bit is a self-clearing pulse.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
            link_cfg <= LINK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata & 32'h0000_0003;
            end
            if (wr_link) begin
                link_cfg <= reg_wdata & 32'h0000_000f;
            end
        end
    end

    // Update request; a new request in the accepting cycle wins.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            update_req <= 1'b0;
        end else if (wr_ctrl && reg_wdata[CTRL_UPDATE_BIT]) begin
            update_req <= 1'b1;
        end else if (state == ST_UPDATE) begin
            update_req <= 1'b0;
        end
    end

    // Link settings are frozen once training is allowed, so the fabric
    // load and the user application run on one identical setting.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            latched_rate <= RATE_GEN1;
            latched_width <= WIDTH_X1;
        end else if (!periphery_done) begin
            latched_rate <= rate_ok ? req_rate : RATE_GEN1;
            latched_width <= width_ok ? req_width : WIDTH_X1;
        end
    end

    // Done indicators and the initialization timer.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            periphery_done <= 1'b0;
            fabric_done <= 1'b0;
            init_done <= 1'b0;
            user_mode <= 1'b0;
            init_cnt <= '0;
        end else begin
            if (conv_done && (state == ST_PERIPH || state == ST_FULL)) begin
                periphery_done <= 1'b1;
            end
            // A full load carries the fabric, so it completes that too.
            if (full_loaded) begin
                fabric_done <= 1'b1;
            end else if (image_end) begin
                fabric_done <= 1'b1;
            end else if (next_state == ST_UPDATE && state == ST_USER) begin
                fabric_done <= 1'b0;
            end
            if (next_state == ST_INIT && state != ST_INIT) begin
                init_cnt <= ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1);
            end else if (init_cnt != '0) begin
                init_cnt <= init_cnt - 1'b1;
            end
            user_mode <= (next_state == ST_USER);
            // Init done only shows when software enabled it.
            init_done <= init_en && (next_state == ST_USER ||
                (init_done && next_state != ST_UPDATE));
        end
    end

    // Completions once periphery is done: retry or unsupported until the fabric runs.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cpl_valid <= 1'b0;
            cpl_status <= CPL_OK;
        end else begin
            cpl_valid <= req_valid && periphery_done;
            if (fabric_up && state == ST_USER) begin
                cpl_status <= CPL_OK;
            end else if (req_is_cfg) begin
                cpl_status <= CPL_RETRY;
            end else begin
                cpl_status <= CPL_UNSUP;
            end
        end
    end

    // Counter of fabric words written for the current image.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            word_count <= '0;
        end else if (state == ST_USER && next_state == ST_UPDATE) begin
            word_count <= '0;
        end else if (cfg_valid && cfg_ready) begin
            word_count <= word_count + 32'h0000_0001;
        end
    end

    // Status word: both done flags together mean fully configured.
    wire [31:0] status_word = {22'h0, state, user_mode, init_done,
        fabric_done && periphery_done};

    // Read decode as an if/else-if chain; unmapped reads return zero.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == REG_CTRL) begin
            reg_rdata <= ctrl;
        end else if (reg_addr == REG_LINK) begin
            reg_rdata <= {28'h0, latched_width, latched_rate};
        end else if (reg_addr == REG_STATUS) begin
            reg_rdata <= status_word;
        end else if (reg_addr == REG_COUNT) begin
            reg_rdata <= word_count;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// *** pfcs_sequencer_properties.sv ***
`timescale 1ns/1ps
// Port-level checks on gating, ordering and completions of the sequencer.
module pfcs_sequencer_properties
    import pfcs_pkg::*;
(
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic reg_rd, // Read strobe.
    input wire logic [31:0] reg_rdata, // Read data.
    input wire logic req_valid, // Host request.
    input wire logic req_is_cfg, // Configuration access.
    input wire logic cpl_valid, // Completion strobe.
    input wire logic [1:0] cpl_status, // Completion status.
    input wire logic train_enable, // Training gate.
    input wire logic [1:0] link_rate, // Link rate.
    input wire logic [1:0] link_width, // Link width.
    input wire logic img_ready, // Image accept.
    input wire logic other_img_ready, // Other block accept.
    input wire logic periphery_done, // Periphery loaded.
    input wire logic fabric_done, // Fabric loaded.
    input wire logic init_done, // Initialization finished.
    input wire logic user_mode // User mode.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    train_gate_a: assert property (train_enable == periphery_done)
        else $error("training gate differs from periphery flag");
    fabric_order_a: assert property (fabric_done |-> periphery_done)
        else $error("fabric flag high before periphery flag");
    user_entry_a: assert property ($rose(user_mode) |-> fabric_done)
        else $error("user mode entered without fabric loaded");
    init_flag_a: assert property (init_done |-> user_mode)
        else $error("init flag high outside user mode");
    other_refuse_a: assert property (!other_img_ready)
        else $error("second link block accepted image data");
    cpl_retry_a: assert property (req_valid && req_is_cfg &&
        periphery_done && !user_mode |=> cpl_valid && cpl_status == CPL_RETRY)
        else $error("config access before user mode not retried");
    cpl_unsup_a: assert property (req_valid && !req_is_cfg &&
        periphery_done && !user_mode |=> cpl_valid && cpl_status == CPL_UNSUP)
        else $error("memory access before user mode not refused");
    cpl_user_a: assert property (req_valid && user_mode
        |=> cpl_valid && cpl_status == CPL_OK)
        else $error("user mode request not completed normally");
    link_freeze_a: assert property (periphery_done
        |=> $stable(link_rate) && $stable(link_width))
        else $error("link settings moved after periphery load");
    img_window_a: assert property (img_ready
        |-> periphery_done && !fabric_done)
        else $error("image accepted outside the loading phase");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read cycle");
endmodule

// *** pfcs_host_model.sv ***
`timescale 1ns/1ps
// Host at the far end of the designated link; streams one image per start.
module pfcs_host_model
    import pfcs_pkg::*;
#(
    parameter int WORDS = 8, // Words in one image.
    parameter logic [31:0] IMG_BASE = 32'ha500_0000 // First word value.
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic start, // Begin a new image.
    input wire logic link_up, // Link active.
    input wire logic img_ready, // Sequencer accepts.
    output logic img_valid, // Word offered.
    output logic [DATA_W-1:0] img_data, // Offered word.
    output logic img_last, // Final word of the image.
    output int sent // Words accepted so far.
);
    logic active; // An image is in flight.

    // Nothing is offered until the link is active.
    assign img_valid = active && link_up && (sent < WORDS);
    assign img_last = img_valid && (sent == WORDS - 1);
    // Idle lanes show an inverted pattern so stale data never looks valid.
    assign img_data = img_valid ? IMG_BASE + DATA_W'(sent)
                                : ~(IMG_BASE + DATA_W'(sent));

    // Offer advances only at the edge that took the word, so it holds.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            active <= 1'b0;
            sent <= 0;
        end else if (start) begin
            active <= 1'b1;
            sent <= 0;
        end else if (img_valid && img_ready) begin
            sent <= sent + 1;
        end
    end
endmodule

// *** pfcs_sequencer_test.sv ***
`timescale 1ns/1ps
// Self-checking bench for the configuration sequencer.
module pfcs_sequencer_test
    import pfcs_pkg::*;
;
    typedef struct {
        logic [31:0] w;
        logic [1:0] rate;
        logic [1:0] width;
    } pfcs_row_t;
    localparam int WORDS = 8; // Image length sent by the host.
    logic clk_sys, rst_n, reg_wr, reg_rd, conv_done, link_up, img_valid;
    logic img_ready, img_last, other_img_valid, cfg_valid, cfg_ready;
    logic req_valid, req_is_cfg, cpl_valid, train_enable, start;
    logic periphery_done, fabric_done, init_done, user_mode;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, img_data, cfg_data;
    logic [1:0] link_rate, link_width, cpl_status;
    int err_count, num_checks, rx_count, sent;
    // Link settings and the port values they should give in this mode.
    pfcs_row_t rows[6] = '{'{32'h0, RATE_GEN1, WIDTH_X1},
        '{32'h5, RATE_GEN2, WIDTH_X4}, '{32'h9, RATE_GEN2, WIDTH_X8},
        '{32'h2, RATE_GEN1, WIDTH_X1}, '{32'h3, RATE_GEN1, WIDTH_X1},
        '{32'hc, RATE_GEN1, WIDTH_X1}};

    pfcs_sequencer dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .link_up(link_up), .train_enable(train_enable),
        .link_rate(link_rate), .link_width(link_width),
        .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data),
        .img_last(img_last), .other_img_valid(other_img_valid),
        .other_img_ready(), .cfg_data(cfg_data), .cfg_valid(cfg_valid),
        .cfg_ready(cfg_ready), .req_valid(req_valid),
        .req_is_cfg(req_is_cfg), .cpl_valid(cpl_valid),
        .cpl_status(cpl_status), .periphery_done(periphery_done),
        .fabric_done(fabric_done), .init_done(init_done),
        .user_mode(user_mode));
    pfcs_host_model #(.WORDS(WORDS)) host_u (.clk_sys(clk_sys),
        .rst_n(rst_n), .start(start), .link_up(link_up),
        .img_ready(img_ready), .img_valid(img_valid), .img_data(img_data),
        .img_last(img_last), .sent(sent));

    task automatic conclude();
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_flag(input logic a, input logic e);
        num_checks++;
        if (a !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic chk_val(input logic [31:0] a, input logic [31:0] e);
        num_checks++;
        if (a !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk_val(reg_rdata, e);
    endtask
    task automatic host_req(input logic cfg, input logic [1:0] e);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_is_cfg <= cfg;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        #1 chk_flag(cpl_valid, 1'b1);
        chk_val({30'h0, cpl_status}, {30'h0, e});
    endtask
    // Bounded wait on one of the status flags; a hang ends the run.
    task automatic wait_flag(input int which, input logic v);
        logic f;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            #1;
            f = (which == 0) ? periphery_done :
                (which == 1) ? fabric_done : user_mode;
            if (f === v) begin
                return;
            end
        end
        err_count++;
        conclude();
    endtask
    task automatic send_image();
        rx_count = 0;
        @(posedge clk_sys);
        start <= 1'b1;
        link_up <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
    endtask

    // Sink of the configuration array; words must arrive whole and in order.
    always @(posedge clk_sys) begin
        if (rst_n && cfg_valid && cfg_ready) begin
            chk_val(cfg_data, 32'ha500_0000 + 32'(rx_count));
            rx_count = rx_count + 1;
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, conv_done, link_up, start} = '0;
        {req_valid, req_is_cfg, reg_addr, reg_wdata} = '0;
        cfg_ready = 1'b1;
        other_img_valid = 1'b1; // Traffic on the other block is ignored.
        {err_count, num_checks, rx_count} = '0;
        repeat (8) @(posedge clk_sys);
        #1 chk_flag(periphery_done, 1'b0);
        chk_flag(fabric_done, 1'b0);
        @(posedge clk_sys) rst_n <= 1'b1;
        reg_read(REG_CTRL, CTRL_RESET);
        reg_read(REG_LINK, LINK_RESET);
        reg_read(4'h9, 32'h0);
        foreach (rows[i]) begin
            reg_write(REG_LINK, rows[i].w);
            repeat (2) @(posedge clk_sys);
            #1 chk_val({30'h0, link_rate}, {30'h0, rows[i].rate});
            chk_val({30'h0, link_width}, {30'h0, rows[i].width});
        end
        reg_write(REG_LINK, 32'h5);
        conv_done <= 1'b1;
        wait_flag(0, 1'b1);
        chk_flag(train_enable, 1'b1);
        chk_flag(fabric_done, 1'b0);
        host_req(1'b1, CPL_RETRY);
        host_req(1'b0, CPL_UNSUP);
        reg_write(REG_LINK, 32'h0);
        repeat (2) @(posedge clk_sys);
        #1 chk_val({30'h0, link_rate}, {30'h0, RATE_GEN2});
        // Stall the array side so the buffer fills and refuses.
        @(posedge clk_sys) cfg_ready <= 1'b0;
        send_image();
        repeat (20) @(posedge clk_sys);
        #1 chk_flag(sent < WORDS, 1'b1);
        chk_flag(img_ready, 1'b0);
        @(posedge clk_sys) cfg_ready <= 1'b1;
        wait_flag(1, 1'b1);
        repeat (8) @(posedge clk_sys);
        chk_val(32'(rx_count), 32'(WORDS));
        wait_flag(2, 1'b1);
        chk_flag(init_done, 1'b1);
        reg_read(REG_STATUS, {22'h0, 7'(ST_USER), 3'h7});
        host_req(1'b1, CPL_OK);
        reg_write(REG_CTRL, 32'h6);
        wait_flag(1, 1'b0);
        send_image();
        wait_flag(1, 1'b1);
        wait_flag(2, 1'b1);
        repeat (8) @(posedge clk_sys);
        chk_val(32'(rx_count), 32'(WORDS));
        reg_read(REG_COUNT, 32'(WORDS));
        // Second power-up in update-only mode with the init flag disabled.
        @(posedge clk_sys);
        {rst_n, conv_done, link_up} <= '0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_write(REG_CTRL, 32'h1);
        reg_write(REG_LINK, 32'h6);
        repeat (2) @(posedge clk_sys);
        #1 chk_val({30'h0, link_rate}, {30'h0, RATE_GEN3});
        @(posedge clk_sys) conv_done <= 1'b1;
        wait_flag(0, 1'b1);
        @(posedge clk_sys);
        #1 chk_flag(fabric_done, 1'b1);
        wait_flag(2, 1'b1);
        chk_flag(init_done, 1'b0);
        conclude();
    end
endmodule

bind pfcs_sequencer pfcs_sequencer_properties chk_u (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_is_cfg(req_is_cfg), .cpl_valid(cpl_valid),
    .cpl_status(cpl_status), .train_enable(train_enable),
    .link_rate(link_rate), .link_width(link_width), .img_ready(img_ready),
    .other_img_ready(other_img_ready), .periphery_done(periphery_done),
    .fabric_done(fabric_done), .init_done(init_done),
    .user_mode(user_mode));
